// ==== include/ptc_pkg.sv ====
// Shared constants and types for the controller timer and counter cells.
package ptc_pkg;

  // Clock rate and the finest time base of 0.01 s, in microseconds.
  localparam int unsigned CLK_FREQ_HZ = 125_000_000;
  localparam int unsigned BASE_TICK_US = 10_000;
  localparam int unsigned TICK_CYCLES_DEF =
    CLK_FREQ_HZ / 1_000_000 * BASE_TICK_US;

  // Value widths and limits of the cells.
  localparam int unsigned VAL_W = 10;
  localparam logic [9:0] COUNT_MAX = 10'h3E7;
  localparam logic [3:0] DEC_LAST = 4'h9;

  // Register byte offsets on the Avalon-MM slave.
  localparam int unsigned ADDR_W = 6;
  localparam logic [5:0] OFF_T_OP = 6'h00;
  localparam logic [5:0] OFF_T_PRE = 6'h04;
  localparam logic [5:0] OFF_T_STAT = 6'h08;
  localparam logic [5:0] OFF_T_BIN = 6'h0C;
  localparam logic [5:0] OFF_T_BCD = 6'h10;
  localparam logic [5:0] OFF_C_OP = 6'h14;
  localparam logic [5:0] OFF_C_PRE = 6'h18;
  localparam logic [5:0] OFF_C_STAT = 6'h1C;
  localparam logic [5:0] OFF_C_BIN = 6'h20;
  localparam logic [5:0] OFF_C_BCD = 6'h24;

  // Operation word fields: op code in bits 2:0, logic result in bit 8.
  localparam int unsigned OP_LSB = 0;
  localparam int unsigned OP_MSB = 2;
  localparam int unsigned RLO_BIT = 8;

  // Timer operation codes.
  localparam logic [2:0] TOP_PULSE = 3'h0;
  localparam logic [2:0] TOP_EXT = 3'h1;
  localparam logic [2:0] TOP_ON = 3'h2;
  localparam logic [2:0] TOP_LATCH = 3'h3;
  localparam logic [2:0] TOP_OFF = 3'h4;
  localparam logic [2:0] TOP_RESET = 3'h5;

  // Counter operation codes.
  localparam logic [2:0] COP_SET = 3'h0;
  localparam logic [2:0] COP_RESET = 3'h1;
  localparam logic [2:0] COP_UP = 3'h2;
  localparam logic [2:0] COP_DOWN = 3'h3;

  // Preset layout: three BCD digits in 11:0, time base code in 13:12.
  localparam int unsigned PRE_BCD_MSB = 11;
  localparam int unsigned PRE_BASE_LSB = 12;
  localparam int unsigned PRE_BASE_MSB = 13;

  // Time base codes.
  localparam logic [1:0] TB_10MS = 2'h0;
  localparam logic [1:0] TB_100MS = 2'h1;
  localparam logic [1:0] TB_1S = 2'h2;
  localparam logic [1:0] TB_10S = 2'h3;

  // Status bit positions.
  localparam int unsigned ST_SCAN = 0;
  localparam int unsigned ST_RUN = 1;
  localparam int unsigned ST_DONE = 2;
  localparam int unsigned ST_LATCH = 3;
  localparam int unsigned ST_EDGE = 4;

  // Counter word flag positions above the 10-bit value.
  localparam int unsigned CW_SET_F = 13;
  localparam int unsigned CW_UP_F = 14;
  localparam int unsigned CW_DN_F = 15;

  // Reset values.
  localparam logic WREQ_RST = 1'b1;
  localparam logic [13:0] PRESET_RST = 14'h0000;

  // Timer start mode, one-hot.
  typedef enum logic [4:0] {
    TM_PULSE = 5'h01,
    TM_EXT = 5'h02,
    TM_ON = 5'h04,
    TM_LATCH = 5'h08,
    TM_OFF = 5'h10
  } ptc_tmode_e;

endpackage

// ==== src/ptc_tick_gen.sv ====
// Base tick generator: one-cycle pulse every CYCLES clocks.
`timescale 1ns/1ps
module ptc_tick_gen #(
  parameter int unsigned CYCLES = ptc_pkg::TICK_CYCLES_DEF
) (
  input wire logic clk_i,
  input wire logic reset_i,
  output logic tick_o
);
  import ptc_pkg::*;

  localparam int unsigned W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } ptc_tick_s;

  ptc_tick_s s_q;
  ptc_tick_s s_d;

  // Free-running divider; the pulse marks each wrap.
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == LAST) begin
      s_d.cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + {{(W-1){1'b0}}, 1'b1};
    end
  end

  // State register.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_o = s_q.tick;
endmodule

// ==== src/ptc_cells.sv ====
// Timer cell and counter cell behind an Avalon-MM register slave.
`timescale 1ns/1ps

// Operation
// - Pulse starts on first 1, clears on 0.
// - Pulse scans read 1 while running.
// - Preset holds count plus time-base digit.
// - Timer shows time in binary and BCD.
// - Extended pulse starts on 1, ignores 0.
// - On-delay starts on 1, clears on 0.
// - On-delay scan 1 after elapse, start held.
// - Latching starts on 1, scan 1 once elapsed.
// - Latched scan drops only on timer reset.
// - Off-delay starts on falling start result.
// - Off-delay cleared while start result 1.
// - Off-delay scan 1 running or start 1.
// - Counter loads preset only on set rise.
// - Set edge flag lives in counter word.
// - Counter shows count in binary and BCD.
// - Counter reset clears; later counts or sets change it again.
// - Count up on rise, saturate at 999.
// - Count down on rise, saturate at zero.
// - Separate up and down edge flags kept.
// - Counter reset operation clears while 1.
module ptc_cells #(
  parameter int unsigned TICK_CYCLES = ptc_pkg::TICK_CYCLES_DEF
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [ptc_pkg::ADDR_W-1:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  output logic timer_scan_o,
  output logic [9:0] timer_binary_value_output_o,
  output logic [13:0] timer_bcd_value_output_o,
  output logic counter_scan_o,
  output logic [9:0] counter_binary_value_output_o,
  output logic [11:0] counter_bcd_value_output_o
);
  import ptc_pkg::*;

  // The start edge flag t_rlo is shared by every start operation, so a
  // program that mixes start modes on one cell sees one common edge.
  typedef struct packed {
    logic wreq;
    logic [31:0] rdata;
    logic [13:0] t_preset;
    ptc_tmode_e t_mode;
    logic [9:0] t_val;
    logic [1:0] t_base;
    logic t_run;
    logic t_done;
    logic t_rlo;
    logic t_latch;
    logic t_scan;
    logic [13:0] t_bcd;
    logic [3:0] div1;
    logic [3:0] div2;
    logic [3:0] div3;
    logic [11:0] c_preset;
    logic [9:0] c_val;
    logic c_set_f;
    logic c_up_f;
    logic c_dn_f;
    logic c_scan;
    logic [11:0] c_bcd;
  } ptc_state_s;

  // Reset image of the whole cell; the bus parks with waitrequest high.
  localparam ptc_state_s ST_RST = '{
    wreq: WREQ_RST,
    t_preset: PRESET_RST,
    t_mode: TM_PULSE,
    c_preset: PRESET_RST[PRE_BCD_MSB:0],
    default: '0
  };

  ptc_state_s s_q;
  ptc_state_s s_d;
  logic tick;

  // Binary to three BCD digits by shift-and-add; input never exceeds 999.
  function automatic logic [11:0] bin2bcd(input logic [9:0] b);
    logic [21:0] sh;
    sh = {12'h000, b};
    for (int i = 0; i < 10; i++) begin
      if (sh[13:10] > 4'h4) sh[13:10] = sh[13:10] + 4'h3;
      if (sh[17:14] > 4'h4) sh[17:14] = sh[17:14] + 4'h3;
      if (sh[21:18] > 4'h4) sh[21:18] = sh[21:18] + 4'h3;
      sh = {sh[20:0], 1'b0};
    end
    return sh[21:10];
  endfunction

  // BCD to binary; a digit above nine is taken as nine so the result
  // can never pass 999 even if software writes a malformed preset.
  function automatic logic [9:0] bcd2bin(input logic [11:0] d);
    logic [9:0] h;
    logic [9:0] t;
    logic [9:0] o;
    h = {6'h00, (d[11:8] > DEC_LAST) ? DEC_LAST : d[11:8]};
    t = {6'h00, (d[7:4] > DEC_LAST) ? DEC_LAST : d[7:4]};
    o = {6'h00, (d[3:0] > DEC_LAST) ? DEC_LAST : d[3:0]};
    return 10'(h * 10'h064 + t * 10'h00A + o);
  endfunction

  // Byte-lane merge of a register write.
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int k = 0; k < 4; k++) begin
      if (be[k]) r[k*8 +: 8] = new_v[k*8 +: 8];
    end
    return r;
  endfunction

  // Decade chain behind the 10 ms tick gives the three slower bases.
  ptc_tick_gen #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .tick_o(tick)
  );

  // All next-state logic: bus slave, time bases, timer and counter.
  always_comb begin
    logic req;
    logic wr_go;
    logic c1;
    logic c2;
    logic c3;
    logic btick;
    logic [31:0] rd;
    logic [31:0] wv;
    logic [2:0] op;
    logic r;
    logic [9:0] ld;
    logic [31:0] pm;
    req = 1'b0;
    wr_go = 1'b0;
    c1 = 1'b0;
    c2 = 1'b0;
    c3 = 1'b0;
    btick = 1'b0;
    rd = 32'h0000_0000;
    wv = 32'h0000_0000;
    op = 3'h0;
    r = 1'b0;
    ld = 10'h000;
    pm = 32'h0000_0000;
    s_d = s_q;

    // The read data is captured when the request is taken, so a read shows
    // the state of the cycle before its waitrequest drops.
    // Read mux; unmapped offsets and write-only registers read zero.
    case (address_i)
      OFF_T_PRE: rd = {18'h00000, s_q.t_preset};
      OFF_T_STAT: rd = {27'h0000000, s_q.t_rlo, s_q.t_latch, s_q.t_done,
                        s_q.t_run, s_q.t_scan};
      OFF_T_BIN: rd = {22'h000000, s_q.t_val};
      OFF_T_BCD: rd = {18'h00000, s_q.t_bcd};
      OFF_C_PRE: rd = {20'h00000, s_q.c_preset};
      OFF_C_STAT: rd = {31'h00000000, s_q.c_scan};
      OFF_C_BIN: rd = {16'h0000, s_q.c_dn_f, s_q.c_up_f, s_q.c_set_f,
                       3'h0, s_q.c_val};
      OFF_C_BCD: rd = {20'h00000, s_q.c_bcd};
      default: rd = 32'h0000_0000;
    endcase

    // Waitrequest drops for exactly one cycle per request. Holding it
    // high by default keeps the master parked until the data is ready,
    // at the cost of one idle cycle between back-to-back accesses.
    req = read_i | write_i;
    if (s_q.wreq) begin
      if (req) begin
        s_d.wreq = 1'b0;
        s_d.rdata = read_i ? rd : 32'h0000_0000;
      end
    end else begin
      s_d.wreq = 1'b1;
    end
    wr_go = write_i && !s_q.wreq;
    wv = be_merge(32'h0000_0000, writedata_i, byteenable_i);
    op = wv[OP_MSB:OP_LSB];
    r = wv[RLO_BIT];

    // Decade dividers: each stage advances on the carry of the one below.
    c1 = tick && (s_q.div1 == DEC_LAST);
    c2 = c1 && (s_q.div2 == DEC_LAST);
    c3 = c2 && (s_q.div3 == DEC_LAST);
    if (tick) s_d.div1 = c1 ? 4'h0 : s_q.div1 + 4'h1;
    if (c1) s_d.div2 = c2 ? 4'h0 : s_q.div2 + 4'h1;
    if (c2) s_d.div3 = c3 ? 4'h0 : s_q.div3 + 4'h1;
    case (s_q.t_base)
      TB_10MS: btick = tick;
      TB_100MS: btick = c1;
      TB_1S: btick = c2;
      TB_10S: btick = c3;
      default: btick = 1'b0;
    endcase

    // The dividers run free, so the first step after a start may come
    // early by up to one base period; this matches a scanned controller.
    if (s_q.t_run && btick) begin
      if (s_q.t_val <= 10'h001) begin
        s_d.t_val = 10'h000;
        s_d.t_run = 1'b0;
        s_d.t_done = 1'b1;
      end else begin
        s_d.t_val = s_q.t_val - 10'h001;
      end
    end

    // Preset writes; the preset is BCD digits plus the time base code.
    // A new preset only matters at the next start; a running timer keeps
    // the value that it loaded.
    if (wr_go && address_i == OFF_T_PRE) begin
      pm = be_merge({18'h00000, s_q.t_preset}, writedata_i,
                    byteenable_i);
      s_d.t_preset = pm[13:0];
    end
    if (wr_go && address_i == OFF_C_PRE) begin
      pm = be_merge({20'h00000, s_q.c_preset}, writedata_i,
                    byteenable_i);
      s_d.c_preset = pm[11:0];
    end

    // One timer operation per write; the operation wins over a tick.
    ld = bcd2bin(s_q.t_preset[PRE_BCD_MSB:0]);
    if (wr_go && address_i == OFF_T_OP) begin
      if (op == TOP_RESET) begin
        if (r) begin
          s_d.t_val = 10'h000;
          s_d.t_run = 1'b0;
          s_d.t_done = 1'b0;
          s_d.t_latch = 1'b0;
        end
      end else if (op <= TOP_OFF) begin
        s_d.t_rlo = r;
        case (op)
          TOP_PULSE: s_d.t_mode = TM_PULSE;
          TOP_EXT: s_d.t_mode = TM_EXT;
          TOP_ON: s_d.t_mode = TM_ON;
          TOP_LATCH: s_d.t_mode = TM_LATCH;
          default: s_d.t_mode = TM_OFF;
        endcase
        // Start on rise for all modes but off-delay, which starts on fall.
        if ((op == TOP_PULSE || op == TOP_ON) && !r) begin
          s_d.t_val = 10'h000;
          s_d.t_run = 1'b0;
          s_d.t_done = 1'b0;
        end else if (op == TOP_OFF && r) begin
          s_d.t_val = 10'h000;
          s_d.t_run = 1'b0;
          s_d.t_done = 1'b0;
        end else if ((op != TOP_OFF && r && !s_q.t_rlo) ||
                     (op == TOP_OFF && !r && s_q.t_rlo)) begin
          s_d.t_val = ld;
          s_d.t_base = s_q.t_preset[PRE_BASE_MSB:PRE_BASE_LSB];
          s_d.t_run = (ld != 10'h000);
          s_d.t_done = (ld == 10'h000);
        end
      end
    end

    // Latching mode holds its scan once elapsed, until a reset.
    // It reads the next state so the scan rises in the elapsing cycle.
    if (s_d.t_mode == TM_LATCH && s_d.t_done) begin
      s_d.t_latch = 1'b1;
    end

    // Scan result per mode.
    case (s_d.t_mode)
      TM_PULSE: s_d.t_scan = s_d.t_run;
      TM_EXT: s_d.t_scan = s_d.t_run;
      TM_ON: s_d.t_scan = s_d.t_done && s_d.t_rlo;
      TM_LATCH: s_d.t_scan = s_d.t_latch;
      TM_OFF: s_d.t_scan = s_d.t_run || s_d.t_rlo;
      default: s_d.t_scan = 1'b0;
    endcase
    s_d.t_bcd = {s_d.t_base, bin2bcd(s_d.t_val)};

    // Counter operations; set, up and down each keep their own edge flag.
    // A reset leaves the edge flags alone, so a count input held high
    // through a reset does not count again once the reset is released.
    if (wr_go && address_i == OFF_C_OP) begin
      case (op)
        COP_SET: begin
          s_d.c_set_f = r;
          if (r && !s_q.c_set_f) begin
            s_d.c_val = bcd2bin(s_q.c_preset);
          end
        end
        COP_RESET: begin
          if (r) s_d.c_val = 10'h000;
        end
        COP_UP: begin
          s_d.c_up_f = r;
          if (r && !s_q.c_up_f && s_q.c_val < COUNT_MAX) begin
            s_d.c_val = s_q.c_val + 10'h001;
          end
        end
        COP_DOWN: begin
          s_d.c_dn_f = r;
          if (r && !s_q.c_dn_f && s_q.c_val != 10'h000) begin
            s_d.c_val = s_q.c_val - 10'h001;
          end
        end
        default: s_d.c_val = s_q.c_val;
      endcase
    end
    s_d.c_scan = (s_d.c_val != 10'h000);
    s_d.c_bcd = bin2bcd(s_d.c_val);
  end

  // State register.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Every output is a field of the state register.
  assign readdata_o = s_q.rdata;
  assign waitrequest_o = s_q.wreq;
  assign timer_scan_o = s_q.t_scan;
  assign timer_binary_value_output_o = s_q.t_val;
  assign timer_bcd_value_output_o = s_q.t_bcd;
  assign counter_scan_o = s_q.c_scan;
  assign counter_binary_value_output_o = s_q.c_val;
  assign counter_bcd_value_output_o = s_q.c_bcd;
endmodule

// ==== test/ptc_cells_chk.sv ====
// Assertion checker watching the ports of the timer and counter cells.
`timescale 1ns/1ps
module ptc_cells_chk
  import ptc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [5:0] address_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  input wire logic waitrequest_o,
  input wire logic [9:0] timer_binary_value_output_o,
  input wire logic [13:0] timer_bcd_value_output_o,
  input wire logic counter_scan_o,
  input wire logic [9:0] counter_binary_value_output_o,
  input wire logic [11:0] counter_bcd_value_output_o
);
  logic wr_done;
  logic op_full;
  // A write lands only at the edge where waitrequest is seen low.
  assign wr_done = write_i && !waitrequest_o;
  assign op_full = wr_done && byteenable_i == 4'hF && writedata_i[8];

  // Three decimal digits of a binary value.
  function automatic logic [11:0] bcd3(input logic [9:0] v);
    return {4'(v / 100), 4'((v / 10) % 10), 4'(v % 10)};
  endfunction

  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  cnt_scan_a: assert property (
    counter_scan_o == (counter_binary_value_output_o != 10'h000))
    else $error("counter scan disagrees with count");
  cnt_max_a: assert property (
    counter_binary_value_output_o <= COUNT_MAX)
    else $error("count above ceiling");
  cnt_bcd_a: assert property (
    counter_bcd_value_output_o == bcd3(counter_binary_value_output_o))
    else $error("counter decimal output wrong");
  tmr_bcd_a: assert property (
    timer_bcd_value_output_o[11:0] == bcd3(timer_binary_value_output_o))
    else $error("timer decimal output wrong");
  tmr_step_a: assert property (!wr_done |=>
    timer_binary_value_output_o == $past(timer_binary_value_output_o) ||
    timer_binary_value_output_o == $past(timer_binary_value_output_o) - 1)
    else $error("timer moved by more than one step");
  tmr_zero_a: assert property (
    timer_binary_value_output_o == 10'h000 && !wr_done |=>
    timer_binary_value_output_o == 10'h000)
    else $error("timer left zero by itself");
  cnt_hold_a: assert property (
    !wr_done |=> $stable(counter_binary_value_output_o))
    else $error("count changed without an operation");
  cnt_clr_a: assert property (op_full && address_i == OFF_C_OP &&
    writedata_i[2:0] == COP_RESET |=> counter_binary_value_output_o == 0)
    else $error("counter reset did not clear");
  off_clr_a: assert property (op_full && address_i == OFF_T_OP &&
    writedata_i[2:0] == TOP_OFF |=> timer_binary_value_output_o == 0)
    else $error("off-delay with start high did not clear");
endmodule

bind ptc_cells ptc_cells_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_i (.*);

// ==== test/ptc_seq_model.sv ====
// Bus master model standing in for the program sequencer.
`timescale 1ns/1ps
module ptc_seq_model (
  input wire logic clk_i,
  input wire logic [31:0] readdata_i,
  input wire logic waitrequest_i,
  output logic [ptc_pkg::ADDR_W-1:0] address_o,
  output logic read_o,
  output logic write_o,
  output logic [31:0] writedata_o,
  output logic [3:0] byteenable_o
);
  import ptc_pkg::*;
  // Idle bus at time zero; every access uses all byte lanes.
  initial begin
    address_o = '0;
    read_o = 1'b0;
    write_o = 1'b0;
    writedata_o = '0;
    byteenable_o = 4'hF;
  end

  // One access; the request stands until waitrequest is seen low or 64 cycles pass, and a
  // released bus shows inverted values so stale data never looks valid.
  task automatic xfer(input logic wr, input logic [5:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic to);
    int n;
    @(posedge clk_i);
    address_o <= a;
    writedata_o <= d;
    write_o <= wr;
    read_o <= !wr;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (waitrequest_i !== 1'b0 && n < 64);
    q = readdata_i;
    to = (waitrequest_i !== 1'b0);
    write_o <= 1'b0;
    read_o <= 1'b0;
    address_o <= ~a;
    writedata_o <= ~d;
  endtask
endmodule

// ==== test/test_plc_timer_counter_cells.sv ====
// Self-checking bench for the timer and counter cells.
`timescale 1ns/1ps
module test_plc_timer_counter_cells;
  import ptc_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [5:0] address_i;
  logic read_i, write_i, waitrequest_o, timer_scan_o, counter_scan_o;
  logic [31:0] writedata_i, readdata_o, rv;
  logic [3:0] byteenable_i;
  logic [9:0] tbin, cbin;
  logic [13:0] tbcd;
  logic [11:0] cbcd;
  int failures = 0;
  int samples_checked = 0;

  // A short base tick keeps the timed scenarios within a few hundred cycles.
  always #4 clk_i = ~clk_i;

  ptc_cells #(.TICK_CYCLES(4)) DUT (.clk_i(clk_i), .reset_i(reset_i),
    .address_i(address_i), .read_i(read_i), .write_i(write_i),
    .writedata_i(writedata_i), .byteenable_i(byteenable_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .timer_scan_o(timer_scan_o), .timer_binary_value_output_o(tbin),
    .timer_bcd_value_output_o(tbcd), .counter_scan_o(counter_scan_o),
    .counter_binary_value_output_o(cbin), .counter_bcd_value_output_o(cbcd));

  ptc_seq_model seq (.clk_i(clk_i), .readdata_i(readdata_o),
    .waitrequest_i(waitrequest_o), .address_o(address_i), .read_o(read_i),
    .write_o(write_i), .writedata_o(writedata_i),
    .byteenable_o(byteenable_i));

  // Compare, count and report at once.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // A hung bus access ends the run as a mismatch.
  task automatic acc(input logic wr, input logic [5:0] a, input logic [31:0] d);
    logic to;
    seq.xfer(wr, a, d, rv, to);
    if (to) begin
      failures++;
      final_report();
    end
  endtask

  task automatic top(input logic [2:0] op, input logic rlo);
    acc(1'b1, OFF_T_OP, 32'({rlo, 5'h00, op}));
  endtask

  task automatic cop(input logic [2:0] op, input logic rlo);
    acc(1'b1, OFF_C_OP, 32'({rlo, 5'h00, op}));
  endtask

  // Polls the timer scan under a bounded count; the caller judges it.
  task automatic wait_scan(input logic e);
    int n;
    n = 0;
    acc(1'b0, OFF_T_STAT, '0);
    while (rv[0] !== e && n < 300) begin
      acc(1'b0, OFF_T_STAT, '0);
      n++;
    end
  endtask

  task automatic t_pulse();
    acc(1'b1, OFF_T_PRE, 32'h0000_1005);
    top(TOP_PULSE, 1'b1);
    acc(1'b0, OFF_T_STAT, '0);
    chk(32'(rv[0]), 32'h1);
    acc(1'b0, OFF_T_BCD, '0);
    chk(32'(rv[13:12]), 32'h1);
    @(negedge clk_i);
    chk(32'(tbcd[13:12]), 32'h1);
    chk(32'(timer_scan_o), 32'h1);
    top(TOP_PULSE, 1'b0);
    acc(1'b0, OFF_T_BIN, '0);
    chk(rv, 32'h0);
    $display("pulse test finished");
  endtask

  task automatic t_ext();
    acc(1'b1, OFF_T_PRE, 32'h0000_0008);
    top(TOP_EXT, 1'b1);
    top(TOP_EXT, 1'b0);
    acc(1'b0, OFF_T_STAT, '0);
    chk(32'(rv[0]), 32'h1);
    wait_scan(1'b0);
    chk(32'(rv[0]), 32'h0);
    $display("extended pulse test finished");
  endtask

  task automatic t_on();
    acc(1'b1, OFF_T_PRE, 32'h0000_0002);
    top(TOP_ON, 1'b1);
    acc(1'b0, OFF_T_STAT, '0);
    chk(32'(rv[0]), 32'h0);
    wait_scan(1'b1);
    top(TOP_ON, 1'b1);
    acc(1'b0, OFF_T_STAT, '0);
    chk(32'(rv[0]), 32'h1);
    top(TOP_ON, 1'b0);
    acc(1'b0, OFF_T_STAT, '0);
    chk(32'(rv[0]), 32'h0);
    $display("on-delay test finished");
  endtask

  task automatic t_latch();
    top(TOP_LATCH, 1'b1);
    top(TOP_LATCH, 1'b0);
    wait_scan(1'b1);
    chk(32'(rv[0]), 32'h1);
    top(TOP_RESET, 1'b0);
    acc(1'b0, OFF_T_STAT, '0);
    chk(32'(rv[0]), 32'h1);
    top(TOP_RESET, 1'b1);
    acc(1'b0, OFF_T_STAT, '0);
    chk(32'(rv[0]), 32'h0);
    $display("latching test finished");
  endtask

  task automatic t_off();
    acc(1'b1, OFF_T_PRE, 32'h0000_0003);
    top(TOP_OFF, 1'b1);
    acc(1'b0, OFF_T_STAT, '0);
    chk(32'(rv[0]), 32'h1);
    top(TOP_OFF, 1'b0);
    acc(1'b0, OFF_T_STAT, '0);
    chk(32'(rv[1:0]), 32'h3);
    wait_scan(1'b0);
    chk(32'(rv[0]), 32'h0);
    @(negedge clk_i);
    chk(32'(timer_scan_o), 32'h0);
    $display("off-delay test finished");
  endtask

  task automatic t_cnt();
    acc(1'b1, OFF_C_PRE, 32'h0000_0998);
    cop(COP_SET, 1'b1);
    acc(1'b0, OFF_C_BIN, '0);
    chk(32'(rv[13:0]), 32'h23E6);
    acc(1'b0, OFF_C_BCD, '0);
    chk(rv, 32'h998);
    acc(1'b1, OFF_C_PRE, 32'h0000_0005);
    cop(COP_SET, 1'b1);
    cop(COP_UP, 1'b0);
    cop(COP_UP, 1'b1);
    cop(COP_UP, 1'b1);
    acc(1'b0, OFF_C_BIN, '0);
    chk(32'(rv[9:0]), 32'(COUNT_MAX));
    cop(COP_UP, 1'b0);
    cop(COP_UP, 1'b1);
    cop(COP_DOWN, 1'b1);
    acc(1'b0, OFF_C_BIN, '0);
    chk(32'(rv[9:0]), 32'h3E6);
    cop(COP_RESET, 1'b1);
    cop(COP_RESET, 1'b0);
    cop(COP_DOWN, 1'b0);
    cop(COP_DOWN, 1'b1);
    @(negedge clk_i);
    chk({counter_scan_o, 21'h0, cbin}, 32'h0);
    acc(1'b0, 6'h3C, '0);
    chk(rv, 32'h0);
    $display("counter test finished");
  endtask

  // Reset for 20 cycles, then run every scenario once.
  initial begin
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    t_pulse();
    t_ext();
    t_on();
    t_latch();
    t_off();
    t_cnt();
    final_report();
  end
endmodule
